// ===== hdl/cmp_cfg.svh
// Register map, field positions, widths and reset values of the comparator control block
`ifndef CMP_CFG_SVH
`define CMP_CFG_SVH

`define CMP_ADDR_W        4
`define CMP_DATA_W        32
`define CMP_REG_N         10
`define CMP_REG_MAIN      4'h0
`define CMP_REG_EDGE      4'h1
`define CMP_REG_NSEL      4'h2
`define CMP_REG_PSEL      4'h3
`define CMP_REG_SHARED    4'h4
`define CMP_REG_ROUTE     4'h5
`define CMP_REG_DIR       4'h6
`define CMP_REG_IRQ_STAT  4'h7
`define CMP_REG_IRQ_CLR   4'h8
`define CMP_REG_IRQ_EN    4'h9

`define CMP_MAIN_EN_BIT   7
`define CMP_MAIN_OUT_BIT  6
`define CMP_MAIN_POL_BIT  4
`define CMP_EDGE_RISE_BIT 1
`define CMP_EDGE_FALL_BIT 0
`define CMP_ROUTE_EN_BIT  7
`define CMP_IRQ_BIT       0
`define CMP_SHARED_BIT    0

`define CMP_SEL_W         3
`define CMP_PIN_N         8
`define CMP_PIN_IDX_W     3
`define CMP_DIR_RESET     8'hff
`define CMP_TCY_W         2
`define CMP_TCY_LAST      2'h3
`define CMP_TCY_STEP      2'h1

`endif

// ===== hdl/cmp_pkg.sv
// Types shared by the comparator control block
`include "cmp_cfg.svh"

package cmp_pkg;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_t;

    typedef struct packed {
        bus_state_t                  bus;
        logic                        waitrequest;
        logic [`CMP_DATA_W-1:0]      readdata;
        logic                        enable;
        logic                        invert;
        logic                        rise_en;
        logic                        fall_en;
        logic [`CMP_SEL_W-1:0]       neg_sel;
        logic [`CMP_SEL_W-1:0]       pos_sel;
        logic                        route_en;
        logic [`CMP_PIN_IDX_W-1:0]   route_pin;
        logic [`CMP_PIN_N-1:0]       pin_dir;
        logic                        raw_meta;
        logic                        raw_sync;
        logic [`CMP_TCY_W-1:0]       tcy_cnt;
        logic                        result;
        logic                        irq_flag;
        logic                        irq_en;
        logic                        irq;
        logic                        power_on;
        logic [`CMP_PIN_N-1:0]       pin_out;
        logic [`CMP_PIN_N-1:0]       pin_oe;
    } cmp_state_t;

endpackage

// ===== hdl/analog_comparator_control.sv
// Control, status, edge interrupt and pin routing for one analog comparator channel
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "cmp_cfg.svh"

// How it works
// - The comparator is only run, and its result only tracked, while the enable bit is set.
// - Clearing the enable bit powers the comparator core down and holds the result low.
// - The result is readable both in the main control register and in the shared result register.
// - The result drives the routed pin only while that pin's direction bit is clear.
// - The internal result is latched once per instruction cycle; the pin copy is not.
// - The invert bit flips the result, the same as swapping the two inputs.
// - Uninverted, the result is 1 when the negative input is below the positive input, else 0.
// - With the rising enable set, each low-to-high result change while the enable bit stays set sets the interrupt flag.
// - With the falling enable set, each high-to-low result change while the enable bit stays set sets the interrupt flag; the drop on disable does not.
// - Bits 7 to 2 of the edge control register read as zero.
// - Positive and negative input channels come from two separate selection registers.
module analog_comparator_control
    import cmp_pkg::*;
(
    input  wire logic                       clk,              // 250 MHz system clock
    input  wire logic                       reset_n,          // Asynchronous reset, active low
    input  wire logic [`CMP_ADDR_W-1:0]     address,          // Avalon word address
    input  wire logic                       read,             // Avalon read request
    input  wire logic                       write,            // Avalon write request
    input  wire logic [`CMP_DATA_W-1:0]     writedata,        // Avalon write data
    input  wire logic [3:0]                 byteenable,       // Avalon byte enables
    output logic      [`CMP_DATA_W-1:0]     readdata,         // Avalon read data
    output logic                            waitrequest,      // Avalon wait request
    input  wire logic                       cmp_raw,          // Core output, 1 when negative below positive
    output logic                            cmp_power_on,     // Core power, low for lowest consumption
    output logic      [`CMP_SEL_W-1:0]      neg_input_select, // Negative input channel
    output logic      [`CMP_SEL_W-1:0]      pos_input_select, // Positive input channel
    output logic      [`CMP_PIN_N-1:0]      pin_out,          // Pin output levels
    output logic      [`CMP_PIN_N-1:0]      pin_oe,           // Pin output enables
    output logic                            irq               // Level interrupt
);

    cmp_state_t s;
    cmp_state_t n;

    // One-hot register decode, shared by reads and writes
    function automatic logic [`CMP_REG_N-1:0] reg_sel(input logic [`CMP_ADDR_W-1:0] a);
        logic [`CMP_REG_N-1:0] v;
        v = '0;
        case (a)
            `CMP_REG_MAIN:     v[0] = 1'b1;
            `CMP_REG_EDGE:     v[1] = 1'b1;
            `CMP_REG_NSEL:     v[2] = 1'b1;
            `CMP_REG_PSEL:     v[3] = 1'b1;
            `CMP_REG_SHARED:   v[4] = 1'b1;
            `CMP_REG_ROUTE:    v[5] = 1'b1;
            `CMP_REG_DIR:      v[6] = 1'b1;
            `CMP_REG_IRQ_STAT: v[7] = 1'b1;
            `CMP_REG_IRQ_CLR:  v[8] = 1'b1;
            `CMP_REG_IRQ_EN:   v[9] = 1'b1;
            default:           v = '0;
        endcase
        return v;
    endfunction

    // Read mux; unmapped and write-only words read as zero
    function automatic logic [`CMP_DATA_W-1:0] read_word(input logic [`CMP_REG_N-1:0] sel,
                                                         input cmp_state_t st);
        logic [`CMP_DATA_W-1:0] w;
        w = '0;
        if (sel[0]) begin
            w[`CMP_MAIN_EN_BIT]  = st.enable;
            w[`CMP_MAIN_OUT_BIT] = st.result;
            w[`CMP_MAIN_POL_BIT] = st.invert;
        end
        if (sel[1]) begin
            w[`CMP_EDGE_RISE_BIT] = st.rise_en;
            w[`CMP_EDGE_FALL_BIT] = st.fall_en;
        end
        if (sel[2]) begin
            w[`CMP_SEL_W-1:0] = st.neg_sel;
        end
        if (sel[3]) begin
            w[`CMP_SEL_W-1:0] = st.pos_sel;
        end
        if (sel[4]) begin
            w[`CMP_SHARED_BIT] = st.result;
        end
        if (sel[5]) begin
            w[`CMP_ROUTE_EN_BIT]    = st.route_en;
            w[`CMP_PIN_IDX_W-1:0]   = st.route_pin;
        end
        if (sel[6]) begin
            w[`CMP_PIN_N-1:0] = st.pin_dir;
        end
        if (sel[7]) begin
            w[`CMP_IRQ_BIT] = st.irq_flag;
        end
        if (sel[9]) begin
            w[`CMP_IRQ_BIT] = st.irq_en;
        end
        return w;
    endfunction

    logic [`CMP_REG_N-1:0] sel;
    logic                  wr;
    logic                  irq_clr;
    logic                  tick;
    logic                  sample;
    logic                  live;
    logic                  rise;
    logic                  fall;

    always_comb begin
        n       = s;
        sel     = reg_sel(address);
        wr      = write && (s.bus == BUS_ACK) && byteenable[0];
        irq_clr = wr && sel[8] && writedata[`CMP_IRQ_BIT];

        // Two-stage synchroniser for the asynchronous core output
        n.raw_meta = cmp_raw;
        n.raw_sync = s.raw_meta;

        // Bus handshake: accept, then one cycle with waitrequest low
        case (s.bus)
            BUS_IDLE: begin
                if (read || write) begin
                    n.bus         = BUS_ACK;
                    n.waitrequest = 1'b0;
                    n.readdata    = read ? read_word(sel, s) : '0;
                end
            end
            BUS_ACK: begin
                n.bus         = BUS_IDLE;
                n.waitrequest = 1'b1;
            end
            default: begin
                n.bus         = BUS_IDLE;
                n.waitrequest = 1'b1;
            end
        endcase

        // Register writes land at the edge that completes the transfer
        if (wr && sel[0]) begin
            n.enable = writedata[`CMP_MAIN_EN_BIT];
            n.invert = writedata[`CMP_MAIN_POL_BIT];
        end
        if (wr && sel[1]) begin
            n.rise_en = writedata[`CMP_EDGE_RISE_BIT];
            n.fall_en = writedata[`CMP_EDGE_FALL_BIT];
        end
        if (wr && sel[2]) begin
            n.neg_sel = writedata[`CMP_SEL_W-1:0];
        end
        if (wr && sel[3]) begin
            n.pos_sel = writedata[`CMP_SEL_W-1:0];
        end
        if (wr && sel[5]) begin
            n.route_en  = writedata[`CMP_ROUTE_EN_BIT];
            n.route_pin = writedata[`CMP_PIN_IDX_W-1:0];
        end
        if (wr && sel[6]) begin
            n.pin_dir = writedata[`CMP_PIN_N-1:0];
        end
        if (wr && sel[9]) begin
            n.irq_en = writedata[`CMP_IRQ_BIT];
        end

        // Instruction cycle timebase
        n.tcy_cnt = s.tcy_cnt + `CMP_TCY_STEP;
        tick      = (s.tcy_cnt == `CMP_TCY_LAST);

        // core reports 1 when negative below positive
        sample = s.raw_sync ^ s.invert;

        n.power_on = n.enable;

        if (!n.enable) begin
            n.result = 1'b0;
        end else if (tick) begin
            n.result = sample;
        end

        rise = tick && s.enable && n.enable && !s.result && sample;
        fall = tick && s.enable && n.enable && s.result && !sample;

        n.irq_flag = (s.irq_flag && !irq_clr) || (rise && s.rise_en) || (fall && s.fall_en);
        n.irq      = n.irq_flag && n.irq_en;

        live = s.enable && sample;
        for (int i = 0; i < `CMP_PIN_N; i++) begin
            n.pin_oe[i]  = n.route_en && (n.route_pin == `CMP_PIN_IDX_W'(i)) && !n.pin_dir[i];
            n.pin_out[i] = n.pin_oe[i] && live;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s             <= '0;
            s.bus         <= BUS_IDLE;
            s.waitrequest <= 1'b1;
            s.pin_dir     <= `CMP_DIR_RESET;
        end else begin
            s <= n;
        end
    end

    assign readdata         = s.readdata;
    assign waitrequest      = s.waitrequest;
    assign cmp_power_on     = s.power_on;
    assign neg_input_select = s.neg_sel;
    assign pos_input_select = s.pos_sel;
    assign pin_out          = s.pin_out;
    assign pin_oe           = s.pin_oe;
    assign irq              = s.irq;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    bus_answer_bound_a: assert property (
        (read || write) && s.bus == BUS_IDLE |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not given in one cycle");

    disabled_result_low_a: assert property (
        !s.enable && $past(!s.enable) |-> !s.result && !(|s.pin_out))
        else $error("result active while disabled");

    power_follows_enable_a: assert property (
        $fell(s.enable) |-> !cmp_power_on ##1 !cmp_power_on || s.enable)
        else $error("core still powered after disable");

    shared_result_read_a: assert property (
        read && s.bus == BUS_IDLE && address == `CMP_REG_SHARED
        |=> readdata == {{(`CMP_DATA_W-1){1'b0}}, $past(s.result)})
        else $error("shared result read mismatch");

    pin_oe_direction_a: assert property (
        (pin_oe & s.pin_dir) == '0 && $countones(pin_oe) <= 1)
        else $error("pin driven while direction is input");

    latch_on_tick_a: assert property (
        $changed(s.result) && s.enable && $past(s.enable) |-> $past(s.tcy_cnt) == `CMP_TCY_LAST)
        else $error("result latched outside instruction cycle");

    polarity_applied_a: assert property (
        s.enable && $past(s.tcy_cnt) == `CMP_TCY_LAST && $past(s.invert)
        |-> s.result == !$past(s.raw_sync))
        else $error("inverted result wrong");

    plain_result_a: assert property (
        s.enable && $past(s.tcy_cnt) == `CMP_TCY_LAST && !$past(s.invert)
        |-> s.result == $past(s.raw_sync))
        else $error("uninverted result wrong");

    rise_sets_flag_a: assert property (
        rise && s.rise_en |=> s.irq_flag ##1 (s.irq_flag || $past(irq_clr)))
        else $error("rising edge did not set flag");

    fall_sets_flag_a: assert property (
        fall && s.fall_en |=> s.irq_flag)
        else $error("falling edge did not set flag");

    edge_reserved_zero_a: assert property (
        read && s.bus == BUS_IDLE && address == `CMP_REG_EDGE |=> readdata[`CMP_DATA_W-1:2] == '0)
        else $error("reserved edge bits read nonzero");

    select_written_a: assert property (
        wr && sel[2] |=> neg_input_select == $past(writedata[`CMP_SEL_W-1:0]) && $stable(pos_input_select))
        else $error("negative select not written alone");

    flag_sticky_a: assert property (
        s.irq_flag && !irq_clr |=> s.irq_flag && (irq == s.irq_en))
        else $error("interrupt flag dropped without clear");

    waitrequest_pulse_a: assert property (
        !waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");

    idle_waits_a: assert property (
        s.bus == BUS_IDLE |-> waitrequest)
        else $error("waitrequest low while idle");

    readdata_upper_zero_a: assert property (
        !waitrequest |-> readdata[`CMP_DATA_W-1:8] == '0)
        else $error("read data above the low byte nonzero");

    main_result_read_a: assert property (
        read && s.bus == BUS_IDLE && address == `CMP_REG_MAIN
        |=> readdata[`CMP_MAIN_OUT_BIT] == $past(s.result))
        else $error("main control result bit mismatch");

    powered_off_low_a: assert property (
        !cmp_power_on |-> !s.result)
        else $error("result set while core powered off");

    disabled_no_flag_a: assert property (
        !s.enable |=> !$rose(s.irq_flag))
        else $error("interrupt flag set while disabled");

    flag_needs_edge_a: assert property (
        $rose(s.irq_flag) |-> $past((rise && s.rise_en) || (fall && s.fall_en)))
        else $error("interrupt flag set without an enabled edge");

    flag_clears_a: assert property (
        irq_clr && !(rise && s.rise_en) && !(fall && s.fall_en) |=> !s.irq_flag)
        else $error("interrupt flag not cleared");

    irq_level_a: assert property (
        irq == (s.irq_flag && s.irq_en))
        else $error("interrupt level does not follow flag and enable");

    pin_unlatched_a: assert property (
        |pin_oe |-> (|pin_out) == $past(s.enable && (s.raw_sync ^ s.invert)))
        else $error("routed pin does not follow the live result");

    pin_within_oe_a: assert property (
        (pin_out & ~pin_oe) == '0)
        else $error("pin level set on a pin that is not driven");

    pos_select_written_a: assert property (
        wr && sel[3] |=> pos_input_select == $past(writedata[`CMP_SEL_W-1:0]) && $stable(neg_input_select))
        else $error("positive select not written alone");

    tick_period_a: assert property (
        tick |=> !tick ##1 !tick ##1 !tick ##1 tick)
        else $error("instruction cycle not four clocks");

    main_written_a: assert property (
        wr && sel[0]
        |=> s.invert == $past(writedata[`CMP_MAIN_POL_BIT]) && s.enable == $past(writedata[`CMP_MAIN_EN_BIT]))
        else $error("main control not written");

    edge_ctrl_written_a: assert property (
        wr && sel[1]
        |=> s.rise_en == $past(writedata[`CMP_EDGE_RISE_BIT]) && s.fall_en == $past(writedata[`CMP_EDGE_FALL_BIT]))
        else $error("edge control not written");

    irq_enable_written_a: assert property (
        wr && sel[9] |=> s.irq_en == $past(writedata[`CMP_IRQ_BIT]))
        else $error("interrupt enable not written");

    route_written_a: assert property (
        wr && sel[5]
        |=> s.route_en == $past(writedata[`CMP_ROUTE_EN_BIT]) && s.route_pin == $past(writedata[`CMP_PIN_IDX_W-1:0]))
        else $error("pin route not written");

endmodule

// ===== dv/cmp_core_model.sv
// Analog comparator core model: selected channel voltages in, raw decision out
`timescale 1ns/1ns
`include "cmp_cfg.svh"
module cmp_core_model (
    input  wire logic                  clk,      // System clock
    input  wire logic                  power_on, // Core powered
    input  wire logic [`CMP_SEL_W-1:0] neg_sel,  // Negative channel
    input  wire logic [`CMP_SEL_W-1:0] pos_sel,  // Positive channel
    input  wire logic [15:0]           volt [8], // Channel voltages in mV
    output logic                       cmp_raw   // 1 when negative below positive
);
    logic junk_r = 1'b0;

    // Powered down, the output is junk that changes every cycle
    always @(posedge clk) junk_r <= ~junk_r;

    always_comb begin
        if (power_on) cmp_raw = (volt[neg_sel] < volt[pos_sel]);
        else cmp_raw = junk_r;
    end
endmodule

// ===== dv/analog_comparator_control_tb.sv
// Self-checking testbench of the comparator control block
`timescale 1ns/1ns
`include "cmp_cfg.svh"
module analog_comparator_control_tb;
    import cmp_pkg::*;
    logic        clk, reset_n, read, write, waitrequest, cmp_raw, cmp_power_on, irq;
    logic [3:0]  address, byteenable;
    logic [31:0] writedata, readdata;
    logic [2:0]  nsel, psel, ns, ps;
    logic [7:0]  pin_out, pin_oe;
    logic [15:0] volt [8];
    logic        inv, hi, res;
    logic [3:0]  qa [$];
    logic [31:0] qe [$];
    int          errors, n_tests;

    analog_comparator_control uut (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .cmp_raw(cmp_raw), .cmp_power_on(cmp_power_on),
        .neg_input_select(nsel), .pos_input_select(psel), .pin_out(pin_out), .pin_oe(pin_oe),
        .irq(irq));
    cmp_core_model core (.clk(clk), .power_on(cmp_power_on), .neg_sel(nsel), .pos_sel(psel),
        .volt(volt), .cmp_raw(cmp_raw));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic is_wr, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        address <= a;
        read <= ~is_wr;
        write <= is_wr;
        writedata <= {24'($urandom), d};
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            errors++;
            final_report();
        end
        read <= 1'b0;
        write <= 1'b0;
        // Let one edge pass so a following call never reassigns the strobes in this time step
        @(posedge clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        qa.push_back(a);
        qe.push_back({24'h0, e});
        bus(1'b0, a, 8'h00);
    endtask

    // Drives the selected pair so the raw decision is hi, then lets the latch follow
    task automatic set_in(input logic h);
        volt[ns] <= 16'h05dc;
        volt[ps] <= h ? 16'h07d0 : 16'h03e8;
        repeat (12) @(posedge clk);
    endtask

    always @(posedge clk) begin
        if (read === 1'b1 && waitrequest === 1'b0) begin
            check($sformatf("reg %h", qa.pop_front()), qe.pop_front(), readdata);
        end
    end

    initial begin
        errors = 0;
        n_tests = 0;
        reset_n = 1'b0;
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'hf;
        for (int i = 0; i < 8; i++) volt[i] = 16'h0;
        void'($urandom(32'hc5c9d089));
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 16; a++) rd(a[3:0], (a == 6) ? 8'hff : 8'h00);
        check("power", 32'h0, 32'(cmp_power_on));
        wr(4'h1, 8'hff);
        rd(4'h1, 8'h03);
        ns = 3'($urandom);
        ps = ns + 3'(1 + $urandom % 7);
        wr(4'h2, {5'h0, ns});
        wr(4'h3, {5'h0, ps});
        rd(4'h2, {5'h0, ns});
        rd(4'h3, {5'h0, ps});
        check("selects", {26'h0, ns, ps}, {26'h0, nsel, psel});
        for (int k = 0; k < 4; k++) begin
            inv = k[1];
            hi = k[0];
            res = hi ^ inv;
            wr(4'h0, {3'b100, inv, 4'h0});
            set_in(hi);
            rd(4'h0, {1'b1, res, 1'b0, inv, 4'h0});
            rd(4'h4, {7'h0, res});
            check("power", 32'h1, 32'(cmp_power_on));
        end
        wr(4'h0, 8'h80);
        set_in(1'b0);
        wr(4'h1, 8'h02);
        wr(4'h9, 8'h01);
        wr(4'h8, 8'h01);
        rd(4'h7, 8'h00);
        set_in(1'b1);
        rd(4'h7, 8'h01);
        check("irq", 32'h1, 32'(irq));
        wr(4'h9, 8'h00);
        repeat (2) @(posedge clk);
        check("irq", 32'h0, 32'(irq));
        rd(4'h7, 8'h01);
        wr(4'h8, 8'h01);
        set_in(1'b0);
        rd(4'h7, 8'h00);
        wr(4'h1, 8'h01);
        set_in(1'b1);
        rd(4'h7, 8'h00);
        set_in(1'b0);
        rd(4'h7, 8'h01);
        wr(4'h9, 8'h01);
        repeat (2) @(posedge clk);
        check("irq", 32'h1, 32'(irq));
        wr(4'h8, 8'h01);
        repeat (2) @(posedge clk);
        check("irq", 32'h0, 32'(irq));
        wr(4'h5, 8'h83);
        wr(4'h6, 8'hf7);
        set_in(1'b1);
        check("pin", 32'h0808, {16'h0, pin_oe, pin_out});
        wr(4'h6, 8'hff);
        repeat (2) @(posedge clk);
        check("pin", 32'h0, {16'h0, pin_oe, pin_out});
        wr(4'h8, 8'h01);
        wr(4'h0, 8'h00);
        repeat (12) @(posedge clk);
        check("power", 32'h0, 32'(cmp_power_on));
        rd(4'h0, 8'h00);
        rd(4'h4, 8'h00);
        rd(4'h7, 8'h00);
        final_report();
    end
endmodule
